// *** dv/mfdio_lines_model.sv ***
// model of the external digital lines and the count pulse source
`timescale 1ns/1ps
module mfdio_lines_model (
	// clock
	input wire logic aclk,
	// levels the outside world puts on the port pins
	input wire logic [15:0] line_val,
	// what the block drives
	input wire logic [15:0] digital_port_out_q,
	input wire logic [1:0] digital_port_oe_q,
	// pins seen by the block
	output logic [15:0] digital_port_in,
	output logic count_in
);
	// ****************************************
	// port pins
	// ****************************************
	// a driven port shows the block's own value, an input port the outside level
	always_comb begin
		digital_port_in[7:0] = digital_port_oe_q[0] ? digital_port_out_q[7:0] : line_val[7:0];
		digital_port_in[15:8] = digital_port_oe_q[1] ? digital_port_out_q[15:8] : line_val[15:8];
	end

	// ****************************************
	// pulse source
	// ****************************************
	initial count_in = 1'b0;
	// each level held three cycles so the synchroniser always sees it
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge aclk);
			count_in <= 1'b1;
			repeat (3) @(posedge aclk);
			count_in <= 1'b0;
		end
	endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the multifunction dio block
`timescale 1ns/1ps
`include "mfdio_map.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
	// ****************************************
	// signals
	// ****************************************
	localparam int CW = 4; // short counter so the wrap is reachable
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, oe, alarm;
	logic [15:0] line_val = 16'h0, pins, outv, dac0, dac1;
	logic cnt_in, store;
	int n_errors = 0, n_compared = 0;
	always #4 aclk = ~aclk;

	mfdio_top #(.CW(CW)) mfdio_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.digital_port_in(pins), .digital_port_out_q(outv), .digital_port_oe_q(oe),
		.count_in(cnt_in), .alarm_q(alarm), .alarm_store_q(store),
		.dac0_mv_q(dac0), .dac1_mv_q(dac1));
	mfdio_lines_model mfdio_lines_model_inst (.aclk(aclk), .line_val(line_val),
		.digital_port_out_q(outv), .digital_port_oe_q(oe),
		.digital_port_in(pins), .count_in(cnt_in));

	// ****************************************
	// bus tasks
	// ****************************************
	// address and data offered together, each released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
			if (wvalid && wready) begin dd = 1'b1; wvalid <= 1'b0; end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		`CHK(bresp, er)
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		`CHK(rresp, 2'b00)
		`CHK(rdata, ex)
		rready <= 1'b0;
	endtask
	task automatic rd_err(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		`CHK(rresp, 2'b10)
		rready <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd(`MFDIO_CTRL_OFF, 32'h0);
		rd(`MFDIO_PAT_OFF, 32'hffff0000);
		rd(`MFDIO_DIR_OFF, 32'h0);
		`CHK(oe, 2'b00)
		rd_err(8'h3c);
		wr(8'h3c, 32'h1, 2'b10);
	endtask
	// word write lands low byte on port one; readback is the register, not the pins
	task automatic t_output();
		line_val <= 16'h00ff;
		wr(`MFDIO_DIR_OFF, 32'h3, 2'b00);
		wr(`MFDIO_OUT_OFF, 32'ha55a, 2'b00);
		`CHK(outv, 16'ha55a)
		`CHK(oe, 2'b11)
		rd(`MFDIO_DIR_OFF, 32'h3);
		wr(`MFDIO_DIR_OFF, 32'h0, 2'b00);
		rd(`MFDIO_PIN_OFF, 32'h00ff);
		rd(`MFDIO_OUT_OFF, 32'ha55a);
	endtask
	task automatic t_alarm();
		wr(`MFDIO_PAT_OFF, 32'h000f0005, 2'b00);
		line_val <= 16'h00a5;
		wr(`MFDIO_CTRL_OFF, 32'h1, 2'b00);
		repeat (4) @(posedge aclk);
		`CHK(alarm[0], 1'b0)
		`CHK(store, 1'b0)
		line_val <= 16'h00a4;
		repeat (4) @(posedge aclk);
		`CHK(alarm[0], 1'b1)
		`CHK(store, 1'b0)
		wr(`MFDIO_CTRL_OFF, 32'h5, 2'b00);
		repeat (4) @(posedge aclk);
		`CHK(alarm[0], 1'b0)
		line_val <= 16'h00f5;
		repeat (4) @(posedge aclk);
		`CHK(alarm[0], 1'b1)
		// scan running, port two in match mode with an all-ignore mask
		wr(`MFDIO_CTRL_OFF, 32'h4f, 2'b00);
		repeat (4) @(posedge aclk);
		`CHK(alarm, 2'b11)
		`CHK(store, 1'b1)
		wr(`MFDIO_CTRL_OFF, 32'h0, 2'b00);
		repeat (4) @(posedge aclk);
		`CHK(store, 1'b0)
	endtask
	// measure samples both bytes together and installs the new scan list
	task automatic t_measure();
		line_val <= 16'h1234;
		wr(`MFDIO_CMD_OFF, 32'h301, 2'b00);
		repeat (4) @(posedge aclk);
		rd(`MFDIO_SAMP_OFF, 32'h1234);
		rd(`MFDIO_SCAN_OFF, 32'h3);
		wr(`MFDIO_DIR_OFF, 32'h1, 2'b10);
		rd(`MFDIO_DIR_OFF, 32'h0);
		`CHK(oe, 2'b00)
		wr(`MFDIO_CMD_OFF, 32'h402, 2'b00);
		rd(`MFDIO_SCAN_OFF, 32'h4);
		wr(`MFDIO_DIR_OFF, 32'h1, 2'b00);
		wr(`MFDIO_DIR_OFF, 32'h0, 2'b00);
	endtask
	task automatic t_count();
		mfdio_lines_model_inst.pulse(5);
		repeat (6) @(posedge aclk);
		rd(`MFDIO_CNT_OFF, 32'h5);
		rd(`MFDIO_CNT_OFF, 32'h5);
		wr(`MFDIO_CTRL_OFF, 32'h10, 2'b00);
		rd(`MFDIO_CNT_OFF, 32'h5);
		rd(`MFDIO_CNT_OFF, 32'h0);
		mfdio_lines_model_inst.pulse(3);
		repeat (6) @(posedge aclk);
		wr(`MFDIO_CMD_OFF, 32'h4, 2'b00);
		rd(`MFDIO_CNT_OFF, 32'h0);
		wr(`MFDIO_CTRL_OFF, 32'h20, 2'b00);
		mfdio_lines_model_inst.pulse(2);
		repeat (6) @(posedge aclk);
		rd(`MFDIO_CNT_OFF, 32'h2);
		mfdio_lines_model_inst.pulse((1 << CW) - 2);
		repeat (6) @(posedge aclk);
		rd(`MFDIO_CNT_OFF, 32'h0);
	endtask
	// values at both ends of the range pass, one step beyond is refused
	task automatic t_dac();
		wr(`MFDIO_DAC0_OFF, 32'd12000, 2'b00);
		`CHK(dac0, 16'h2ee0)
		wr(`MFDIO_DAC0_OFF, 32'd12001, 2'b10);
		`CHK(dac0, 16'h2ee0)
		wr(`MFDIO_DAC1_OFF, 32'hffffd120, 2'b00);
		`CHK(dac1, 16'hd120)
		wr(`MFDIO_DAC1_OFF, 32'hffffd11f, 2'b10);
		`CHK(dac1, 16'hd120)
	endtask

	// ****************************************
	// verdict and sequence
	// ****************************************
	task automatic print_verdict();
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_output();
		t_alarm();
		t_measure();
		t_count();
		t_dac();
		print_verdict();
	end
	// the whole sequence needs well under a thousand cycles of pulses and bus traffic
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		print_verdict();
	end
endmodule

// *** logic/mfdio_compare.sv ***
// masked pattern compare alarm for one input port
`timescale 1ns/1ps
module mfdio_compare (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// configuration
	input wire logic enable,
	input wire logic alarm_on_mismatch,
	input wire logic [7:0] mask,
	input wire logic [7:0] pattern,
	// port data and result
	input wire logic [7:0] port_in,
	output logic alarm_q
);
	logic hit;

	// masked equality; mode picks match or mismatch
	assign hit = ((port_in & mask) == (pattern & mask)) ^ alarm_on_mismatch;

	// evaluated every cycle, scan or no scan
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= enable & hit;
		end
	end

	p_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
		(enable && (((port_in ^ pattern) & mask) != 0) && alarm_on_mismatch) |=> alarm_q)
		else $error("mismatch alarm missed");
	p_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!enable |=> !alarm_q) else $error("alarm while disabled");
endmodule

// *** logic/mfdio_map.svh ***
// register offsets, field positions, reset values and limits for the multifunction dio
// Overview of operation
// - compare mask is 8 bits; one marks a compared bit, zero ignores it
// - an enabled compare alarm is evaluated continuously, scan list or not
// - alarm results go to reading memory only while a scan runs
// - both input ports sampled at one instant with one shared time stamp
// - a measure request sweeps the scan list once into the output buffer
// - measure or configure requests replace the scan list with their channels
// - totalizer read policy: plain read keeps count, read-and-reset zeroes it
// - totalizer counts rising edges by default, falling edges when selected
// - a clear-now request zeroes the totalizer at once
// - in read-and-reset mode a direct count read clears the count always; an edge in the same cycle leaves it at one
// - totalizer is 26 bits and wraps to zero after 67,108,863
// - a port in the scan list as an input cannot be made an output
// - output port readback returns the last value written, not the pins
// - port direction reads 0 for input and 1 for output
// - voltage setpoints span -12 V to +12 V in 1 mV steps, read back as set
// - compare alarm fires on match or, by default, on mismatch
// - compare pattern per input port is an 8-bit value 0 to 255
`ifndef MFDIO_MAP_SVH
`define MFDIO_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MFDIO_CTRL_OFF 8'h00
`define MFDIO_STAT_OFF 8'h04
`define MFDIO_PAT_OFF 8'h08
`define MFDIO_OUT_OFF 8'h0c
`define MFDIO_DIR_OFF 8'h10
`define MFDIO_PIN_OFF 8'h14
`define MFDIO_CNT_OFF 8'h18
`define MFDIO_DAC0_OFF 8'h1c
`define MFDIO_DAC1_OFF 8'h20
`define MFDIO_SCAN_OFF 8'h24
`define MFDIO_SAMP_OFF 8'h28
`define MFDIO_CMD_OFF 8'h2c
`define MFDIO_SWEEP_OFF 8'h30

// ****************************************
// field positions
// ****************************************
`define MFDIO_CTRL_CMPEN0 0
`define MFDIO_CTRL_CMPEN1 1
`define MFDIO_CTRL_EQ0 2
`define MFDIO_CTRL_EQ1 3
`define MFDIO_CTRL_RRES 4
`define MFDIO_CTRL_FALL 5
`define MFDIO_CTRL_SCANRUN 6
`define MFDIO_CMD_MEAS 0
`define MFDIO_CMD_CONF 1
`define MFDIO_CMD_CLR 2

// ****************************************
// reset values and limits
// ****************************************
`define MFDIO_CTRL_RST 7'h00
`define MFDIO_DAC_MAX 16'sd12000
`define MFDIO_DAC_MIN (-16'sd12000)
`define MFDIO_CNT_W 26

`endif

// *** logic/mfdio_pkg.sv ***
// types shared by the multifunction dio files
package mfdio_pkg;
	typedef enum logic [2:0] {
		MFDIO_IDLE = 3'b001,
		MFDIO_SAMPLE = 3'b010,
		MFDIO_DONE = 3'b100
	} mfdio_sweep_e;
	typedef logic [7:0] mfdio_byte_t;
endpackage

// *** logic/mfdio_top.sv ***
// multifunction digital io, totalizer and dac setpoints behind an axi4-lite slave
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mfdio_map.svh"
module mfdio_top #(
	parameter int CW = `MFDIO_CNT_W
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// digital ports, three signals each
	input wire logic [15:0] digital_port_in,
	output logic [15:0] digital_port_out_q,
	output logic [1:0] digital_port_oe_q,
	// totalizer pulse source
	input wire logic count_in,
	// compare alarm results and reading memory write
	output logic [1:0] alarm_q,
	output logic alarm_store_q,
	// dac setpoints, signed millivolts
	output logic [15:0] dac0_mv_q,
	output logic [15:0] dac1_mv_q
);
	// ****************************************
	// state
	// ****************************************
	logic [6:0] ctrl_q;
	logic [15:0] mask_q, pat_q;
	logic [2:0] scan_q;
	logic [15:0] samp_q;
	logic [31:0] stamp_q, samp_stamp_q;
	logic sweep_done_q;
	logic [CW-1:0] count;
	logic [1:0] alarm_raw;
	mfdio_pkg::mfdio_sweep_e sweep_q;
	logic aw_hold_q, w_hold_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go, rd_go, rd_cnt, clr_now;
	logic [31:0] rd_val;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;
	logic [31:0] wmerge;

	// ****************************************
	// axi4-lite write path
	// ****************************************
	// address and data latched independently, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

	// byte-lane merge against the current value of the addressed word
	always_comb begin
		wmerge = rd_mux(aw_addr_q);
		for (int i = 0; i < 4; i++) begin
			if (w_strb_q[i]) begin
				wmerge[8*i +: 8] = w_data_q[8*i +: 8];
			end
		end
	end

	// write response; slverr for refused or unmapped writes
	always_comb begin
		wr_resp = 2'b00;
		case (aw_addr_q)
			`MFDIO_CTRL_OFF, `MFDIO_PAT_OFF, `MFDIO_OUT_OFF, `MFDIO_SCAN_OFF,
			`MFDIO_CMD_OFF: wr_resp = 2'b00;
			`MFDIO_DAC0_OFF, `MFDIO_DAC1_OFF: begin
				if (($signed(wmerge[15:0]) > `MFDIO_DAC_MAX) ||
					($signed(wmerge[15:0]) < `MFDIO_DAC_MIN)) begin
					wr_resp = 2'b10;
				end
			end
			`MFDIO_DIR_OFF: begin
				if (|(wmerge[1:0] & scan_q[1:0])) begin
					wr_resp = 2'b10;
				end
			end
			default: wr_resp = 2'b10;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_resp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// refused writes leave the register as it was
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `MFDIO_CTRL_RST;
			mask_q <= 16'hffff;
			pat_q <= 16'h0000;
			digital_port_out_q <= 16'h0000;
			digital_port_oe_q <= 2'b00;
			dac0_mv_q <= 16'h0000;
			dac1_mv_q <= 16'h0000;
		end else if (wr_go && wr_resp == 2'b00) begin
			case (aw_addr_q)
				`MFDIO_CTRL_OFF: ctrl_q <= wmerge[6:0];
				`MFDIO_PAT_OFF: begin
					pat_q <= wmerge[15:0];
					mask_q <= wmerge[31:16];
				end
				`MFDIO_OUT_OFF: digital_port_out_q <= wmerge[15:0];
				`MFDIO_DIR_OFF: digital_port_oe_q <= wmerge[1:0];
				`MFDIO_DAC0_OFF: dac0_mv_q <= wmerge[15:0];
				`MFDIO_DAC1_OFF: dac1_mv_q <= wmerge[15:0];
				default: ;
			endcase
		end
	end

	// measure and configure both replace the scan list
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_q <= 3'b000;
		end else if (wr_go && wr_resp == 2'b00 && aw_addr_q == `MFDIO_CMD_OFF &&
			(wmerge[`MFDIO_CMD_MEAS] || wmerge[`MFDIO_CMD_CONF])) begin
			scan_q <= wmerge[10:8];
		end else if (wr_go && wr_resp == 2'b00 && aw_addr_q == `MFDIO_SCAN_OFF) begin
			scan_q <= wmerge[2:0];
		end
	end

	assign clr_now = wr_go && wr_resp == 2'b00 && aw_addr_q == `MFDIO_CMD_OFF &&
		wmerge[`MFDIO_CMD_CLR];

	// ****************************************
	// single sweep for a measure request
	// ****************************************
	// free running stamp; both bytes share one sample and one stamp
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stamp_q <= 32'h0000_0000;
		end else begin
			stamp_q <= stamp_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sweep_q <= mfdio_pkg::MFDIO_IDLE;
			samp_q <= 16'h0000;
			samp_stamp_q <= 32'h0000_0000;
			sweep_done_q <= 1'b0;
		end else begin
			case (sweep_q)
				mfdio_pkg::MFDIO_IDLE: begin
					if (wr_go && wr_resp == 2'b00 && aw_addr_q == `MFDIO_CMD_OFF &&
						wmerge[`MFDIO_CMD_MEAS]) begin
						sweep_q <= mfdio_pkg::MFDIO_SAMPLE;
						sweep_done_q <= 1'b0;
					end
				end
				mfdio_pkg::MFDIO_SAMPLE: begin
					samp_q <= digital_port_in;
					samp_stamp_q <= stamp_q;
					sweep_q <= mfdio_pkg::MFDIO_DONE;
				end
				mfdio_pkg::MFDIO_DONE: begin
					sweep_done_q <= 1'b1;
					sweep_q <= mfdio_pkg::MFDIO_IDLE;
				end
				default: sweep_q <= mfdio_pkg::MFDIO_IDLE;
			endcase
		end
	end

	// ****************************************
	// compare alarms and totalizer
	// ****************************************
	for (genvar p = 0; p < 2; p++) begin : g_cmp
		mfdio_compare u_cmp (
			.aclk(aclk),
			.aresetn(aresetn),
			.enable(ctrl_q[`MFDIO_CTRL_CMPEN0 + p]),
			.alarm_on_mismatch(!ctrl_q[`MFDIO_CTRL_EQ0 + p]),
			.mask(mask_q[8*p +: 8]),
			.pattern(pat_q[8*p +: 8]),
			.port_in(digital_port_in[8*p +: 8]),
			.alarm_q(alarm_raw[p])
		);
	end

	// alarms always evaluated, stored only during a scan
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_q <= 2'b00;
			alarm_store_q <= 1'b0;
		end else begin
			alarm_q <= alarm_raw;
			alarm_store_q <= (|alarm_raw) & ctrl_q[`MFDIO_CTRL_SCANRUN];
		end
	end

	// count read of the count register feeds read-and-reset
	assign rd_cnt = rd_go && s_axi_araddr == `MFDIO_CNT_OFF;

	mfdio_totalizer #(.CW(CW)) u_tot (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_falling(ctrl_q[`MFDIO_CTRL_FALL]),
		.count_clear_after_read(ctrl_q[`MFDIO_CTRL_RRES]),
		.count_read(rd_cnt),
		.count_clear_now(clr_now),
		.count_in(count_in),
		.count_q(count)
	);

	// ****************************************
	// axi4-lite read path
	// ****************************************
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`MFDIO_CTRL_OFF: v = {25'h0, ctrl_q};
			`MFDIO_STAT_OFF: v = {28'h0, sweep_done_q, alarm_store_q, alarm_q};
			`MFDIO_PAT_OFF: v = {mask_q, pat_q};
			`MFDIO_OUT_OFF: v = {16'h0, digital_port_out_q};
			`MFDIO_DIR_OFF: v = {30'h0, digital_port_oe_q};
			`MFDIO_PIN_OFF: v = {16'h0, digital_port_in};
			`MFDIO_CNT_OFF: v = {{(32-CW){1'b0}}, count};
			`MFDIO_DAC0_OFF: v = {{16{dac0_mv_q[15]}}, dac0_mv_q};
			`MFDIO_DAC1_OFF: v = {{16{dac1_mv_q[15]}}, dac1_mv_q};
			`MFDIO_SCAN_OFF: v = {29'h0, scan_q};
			`MFDIO_SAMP_OFF: v = {16'h0, samp_q};
			`MFDIO_SWEEP_OFF: v = samp_stamp_q;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_val = rd_mux(s_axi_araddr);
	// cmd register reads as zero; unmapped addresses answer slverr
	assign rd_resp = (s_axi_araddr > `MFDIO_SWEEP_OFF || s_axi_araddr[1:0] != 2'b00) ?
		2'b10 : 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	p_dir_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && aw_addr_q == `MFDIO_DIR_OFF && |(wmerge[1:0] & scan_q[1:0]))
		|=> $stable(digital_port_oe_q) && s_axi_bresp == 2'b10)
		else $error("output set on scanned port");
	p_store_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[`MFDIO_CTRL_SCANRUN] |=> !alarm_store_q)
		else $error("alarm stored outside scan");
	p_sweep_once: assert property (@(posedge aclk) disable iff (!aresetn)
		sweep_q == mfdio_pkg::MFDIO_SAMPLE |=> sweep_q == mfdio_pkg::MFDIO_DONE ##1
		sweep_q == mfdio_pkg::MFDIO_IDLE) else $error("sweep not single");
	p_same_stamp: assert property (@(posedge aclk) disable iff (!aresetn)
		sweep_q == mfdio_pkg::MFDIO_SAMPLE |=> samp_stamp_q == $past(stamp_q) &&
		samp_q == $past(digital_port_in)) else $error("ports not sampled together");
	p_readback: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_go && s_axi_araddr == `MFDIO_OUT_OFF) |=>
		s_axi_rdata[15:0] == $past(digital_port_out_q)) else $error("readback wrong");
	p_rres: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_cnt && ctrl_q[`MFDIO_CTRL_RRES]) |=> count <= 1)
		else $error("read did not reset count");
	c_meas: cover property (@(posedge aclk) disable iff (!aresetn)
		sweep_q == mfdio_pkg::MFDIO_DONE);
	c_alarm: cover property (@(posedge aclk) disable iff (!aresetn) alarm_store_q);
	c_refuse: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

// *** logic/mfdio_totalizer.sv ***
// edge counting totalizer with clear-now and read-and-reset
`timescale 1ns/1ps
`include "mfdio_map.svh"
module mfdio_totalizer #(
	parameter int CW = `MFDIO_CNT_W
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// configuration
	input wire logic count_falling,
	input wire logic count_clear_after_read,
	// requests
	input wire logic count_read,
	input wire logic count_clear_now,
	// pulse source and count
	input wire logic count_in,
	output logic [CW-1:0] count_q
);
	logic sync1_q, sync2_q, last_q;
	logic edge_seen;
	logic zero_it;

	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			sync1_q <= count_in;
			sync2_q <= sync1_q;
			last_q <= sync2_q;
		end
	end

	// selected edge only; slope change may cost or add one edge
	assign edge_seen = count_falling ? (last_q & ~sync2_q) : (~last_q & sync2_q);
	assign zero_it = count_clear_now | (count_read & count_clear_after_read);

	// wrap is natural CW-bit overflow; edge during clear counts from zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else if (zero_it) begin
			count_q <= {{(CW-1){1'b0}}, edge_seen};
		end else if (edge_seen) begin
			count_q <= count_q + 1'b1;
		end
	end

	p_clear_from_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		zero_it |=> count_q <= 1) else $error("count not zeroed");
	p_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		(edge_seen && !zero_it && &count_q) |=> count_q == 0) else $error("no wrap");
	p_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(!edge_seen && !zero_it) |=> $stable(count_q)) else $error("count drift");
	c_edge: cover property (@(posedge aclk) disable iff (!aresetn) edge_seen && zero_it);
endmodule
